// ---- verif/bst_tap_monitor.sv ----
// port assertions for the test access port
`timescale 1ns/1ns
`include "bst_map.vh"
module bst_tap_monitor (
  input wire mclk,
  input wire rst_n,
  input wire test_clock,
  input wire test_reset_n,
  input wire test_mode_select,
  input wire test_data_in,
  input wire test_data_out,
  input wire test_data_out_oe,
  input wire [`BST_IN_N-1:0] pin_in,
  input wire [`BST_OUT_N-1:0] core_out,
  input wire core_oe,
  input wire [`BST_OUT_N-1:0] pin_out,
  input wire [`BST_OUT_N-1:0] pin_out_oe,
  input wire [`BST_IR_LEN-1:0] instr,
  input wire [`BST_ID_LEN-1:0] id_latched
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // multi-step conditions
  sequence s_treset_held;
    !test_reset_n [*5];
  endsequence
  sequence s_normal;
    (instr == `BST_OP_IDCODE || instr == `BST_OP_SAMPLE || instr == `BST_OP_BYPASS) [*2];
  endsequence
  sequence s_ext_change;
    (instr == `BST_OP_EXTEST) [*2] ##0 $changed(pin_out);
  endsequence
  // outputs tied to their causes
  property p_treset;
    s_treset_held |-> instr == `BST_OP_IDCODE;
  endproperty
  property p_instr_fall;
    $changed(instr) && instr != `BST_OP_IDCODE |-> !$past(test_clock, 1) && !$past(test_clock, 2);
  endproperty
  property p_tdo_fall;
    $changed(test_data_out) || $changed(test_data_out_oe) |->
      !$past(test_clock, 2) && !$past(test_clock, 3);
  endproperty
  property p_id_update;
    $changed(id_latched) |-> instr == `BST_OP_IDCODE && !$past(test_clock, 2);
  endproperty
  property p_highz;
    (instr == `BST_OP_HIGHZ) [*2] |-> pin_out_oe == 4'h0;
  endproperty
  property p_clamp;
    (instr == `BST_OP_CLAMP) [*3] |-> $stable(pin_out) && $stable(pin_out_oe);
  endproperty
  property p_normal;
    s_normal |-> pin_out == $past(core_out) && pin_out_oe == {4{$past(core_oe)}};
  endproperty
  property p_ext;
    s_ext_change |-> !$past(test_clock, 2);
  endproperty
  a_treset: assert property (p_treset) else $error("test reset ignored");
  a_instr_fall: assert property (p_instr_fall) else $error("instr off edge");
  a_tdo_fall: assert property (p_tdo_fall) else $error("tdo off edge");
  a_id_update: assert property (p_id_update) else $error("id latch bad");
  a_highz: assert property (p_highz) else $error("pins not floated");
  a_clamp: assert property (p_clamp) else $error("clamp moved");
  a_normal: assert property (p_normal) else $error("pins off core");
  a_ext: assert property (p_ext) else $error("extest pin change");
endmodule

// ---- verif/bst_tester.sv ----
// behavioural boundary-scan test controller
`timescale 1ns/1ns
module bst_tester (
  input wire mclk,
  output reg test_clock,
  output reg test_mode_select,
  output reg test_data_in,
  input wire test_data_out
);
  // pins idle, clock rests low outside steps
  initial
  begin
    test_clock = 1'b0;
    test_mode_select = 1'b0;
    test_data_in = 1'b0;
  end
  // one test clock period of eight system clocks
  task step(input tms, input tdi, output tdo);
    begin
      test_mode_select = tms;
      test_data_in = tdi;
      repeat (2) @(negedge mclk);
      test_clock = 1'b1;
      repeat (4) @(negedge mclk);
      tdo = test_data_out;
      test_clock = 1'b0;
      repeat (2) @(negedge mclk);
    end
  endtask
endmodule

// ---- verif/testbench.sv ----
// self-checking bench for the test access port
`timescale 1ns/1ns
`include "bst_map.vh"
module testbench;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg test_reset_n = 1'b1;
  reg [`BST_IN_N-1:0] pin_in = 4'h5;
  reg [`BST_OUT_N-1:0] core_out = 4'h9;
  reg core_oe = 1'b1;
  wire test_clock, test_mode_select, test_data_in, test_data_out, test_data_out_oe;
  wire [`BST_OUT_N-1:0] pin_out;
  wire [`BST_OUT_N-1:0] pin_out_oe;
  wire [`BST_IR_LEN-1:0] instr;
  wire [`BST_ID_LEN-1:0] id_latched;
  localparam [14:0] CODES = {3'h6, 3'h5, `BST_OP_HIGHZ, `BST_OP_CLAMP, `BST_OP_BYPASS};
  reg [31:0] dout;
  reg [2:0] cap;
  integer n_mismatch = 0;
  integer checks = 0;
  integer i;
  // system clock
  always #50 mclk = ~mclk;
  bst_tap bst_tap_inst (.mclk(mclk), .rst_n(rst_n), .test_clock(test_clock),
    .test_reset_n(test_reset_n), .test_mode_select(test_mode_select),
    .test_data_in(test_data_in), .test_data_out(test_data_out),
    .test_data_out_oe(test_data_out_oe), .pin_in(pin_in), .core_out(core_out),
    .core_oe(core_oe), .pin_out(pin_out), .pin_out_oe(pin_out_oe), .instr(instr),
    .id_latched(id_latched));
  bst_tester tester_inst (.mclk(mclk), .test_clock(test_clock),
    .test_mode_select(test_mode_select), .test_data_in(test_data_in),
    .test_data_out(test_data_out));
  task close_out;
    begin
      if (n_mismatch == 0 && checks > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        n_mismatch = n_mismatch + 1;
        $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // mode select walk, first step in bit 0
  task walk(input [7:0] seq, input integer n);
    integer k;
    reg b;
    begin
      for (k = 0; k < n; k = k + 1)
        tester_inst.step(seq[k], 1'b0, b);
    end
  endtask
  // data scan from idle, back to idle through pause-dr and exit2-dr
  task scan_dr(input integer n, input [31:0] din);
    integer k;
    reg b;
    begin
      dout = 32'h0;
      walk(8'h01, 3);
      for (k = 0; k < n; k = k + 1)
      begin
        tester_inst.step(k == n - 1, din[k], b);
        dout[k] = b;
        if (k == 0)
          cmp(test_data_out_oe, 1'b1);
      end
      walk(8'h0c, 5);
    end
  endtask
  task load_ir(input [2:0] op);
    integer k;
    reg b;
    begin
      walk(8'h03, 4);
      for (k = 0; k < 3; k = k + 1)
      begin
        tester_inst.step(k == 2, op[k], b);
        cap[k] = b;
      end
      walk(8'h0c, 5);
    end
  endtask
  task t_reset_id;
    begin
      cmp(instr, `BST_OP_IDCODE);
      cmp(pin_out, core_out);
      walk(8'h00, 1);
      scan_dr(32, 32'hc3a50f96);
      cmp(dout, {`BST_ID_REV, `BST_ID_PART, `BST_ID_MAKER, `BST_ID_MARK});
      cmp(id_latched, 32'hc3a50f96);
      cmp(test_data_out_oe, 1'b0);
    end
  endtask
  task t_bypass;
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        load_ir(CODES[3*i +: 3]);
        cmp(cap, `BST_IR_CAPTURE);
        cmp(instr, CODES[3*i +: 3]);
        scan_dr(8, 32'hb4);
        cmp(dout, 32'h68);
        if (CODES[3*i +: 3] == `BST_OP_HIGHZ)
          cmp(pin_out_oe, 4'h0);
      end
    end
  endtask
  task t_boundary;
    begin
      load_ir(`BST_OP_SAMPLE);
      scan_dr(9, 32'h163);
      cmp(dout, {core_oe, core_out, pin_in});
      load_ir(`BST_OP_EXTEST);
      cmp({pin_out_oe, pin_out}, 8'hf6);
      pin_in = 4'ha;
      scan_dr(9, 32'h030);
      cmp(dout[3:0], 4'ha);
      cmp({pin_out_oe, pin_out}, 8'h03);
      load_ir(`BST_OP_CLAMP);
      cmp(pin_out, 4'h3);
      load_ir(`BST_OP_BYPASS);
      cmp({pin_out_oe, pin_out}, {{4{core_oe}}, core_out});
    end
  endtask
  task t_exits;
    begin
      walk(8'h07, 4);
      cmp(instr, `BST_OP_IDCODE);
      load_ir(`BST_OP_BYPASS);
      test_reset_n = 1'b0;
      repeat (6) @(negedge mclk);
      test_reset_n = 1'b1;
      repeat (4) @(negedge mclk);
      cmp(instr, `BST_OP_IDCODE);
    end
  endtask
  // main sequence
  initial
  begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    repeat (4) @(negedge mclk);
    t_reset_id;
    t_bypass;
    t_boundary;
    t_exits;
    close_out;
  end
  // watchdog
  initial
  begin
    #3000000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
endmodule
bind bst_tap bst_tap_monitor bst_tap_monitor_inst (.mclk(mclk), .rst_n(rst_n),
  .test_clock(test_clock), .test_reset_n(test_reset_n), .test_mode_select(test_mode_select),
  .test_data_in(test_data_in), .test_data_out(test_data_out),
  .test_data_out_oe(test_data_out_oe), .pin_in(pin_in), .core_out(core_out),
  .core_oe(core_oe), .pin_out(pin_out), .pin_out_oe(pin_out_oe), .instr(instr),
  .id_latched(id_latched));

// ---- verilog/bst_map.vh ----
// constants for the boundary scan test access port
`ifndef BST_MAP_VH
`define BST_MAP_VH

// tap controller state codes
`define BST_ST_RESET 4'h0
`define BST_ST_IDLE 4'h1
`define BST_ST_SEL_DR 4'h2
`define BST_ST_CAP_DR 4'h3
`define BST_ST_SHIFT_DR 4'h4
`define BST_ST_EXIT1_DR 4'h5
`define BST_ST_PAUSE_DR 4'h6
`define BST_ST_EXIT2_DR 4'h7
`define BST_ST_UPD_DR 4'h8
`define BST_ST_SEL_IR 4'h9
`define BST_ST_CAP_IR 4'ha
`define BST_ST_SHIFT_IR 4'hb
`define BST_ST_EXIT1_IR 4'hc
`define BST_ST_PAUSE_IR 4'hd
`define BST_ST_EXIT2_IR 4'he
`define BST_ST_UPD_IR 4'hf

// instruction codes
`define BST_IR_LEN 3
`define BST_OP_EXTEST 3'h0
`define BST_OP_IDCODE 3'h1
`define BST_OP_SAMPLE 3'h2
`define BST_OP_CLAMP 3'h3
`define BST_OP_HIGHZ 3'h4
`define BST_OP_BYPASS 3'h7
`define BST_IR_CAPTURE 3'h1

// identification register layout; field values are arbitrary
`define BST_ID_LEN 32
`define BST_ID_REV 4'h2
`define BST_ID_PART 16'h1234
`define BST_ID_MAKER 11'h2aa
`define BST_ID_MARK 1'h1

// boundary chain: input cells, then output cells, then one enable cell
`define BST_IN_N 4
`define BST_OUT_N 4
`define BST_BS_LEN 9
`define BST_BS_OUT_LO 4
`define BST_BS_OUT_HI 7
`define BST_BS_CTL 8

// synchroniser bit positions
`define BST_SY_N 8
`define BST_SY_TCK 0
`define BST_SY_TMS 1
`define BST_SY_TDI 2
`define BST_SY_TRST 3
`define BST_SY_PIN_LO 4
`define BST_SY_PIN_HI 7

`endif

// ---- verilog/bst_sync.v ----
// two-stage synchroniser with one extra stage for edge finding
`timescale 1ns/1ns
module bst_sync #(
  parameter WIDTH = 8
) (
  input wire mclk,
  input wire rst_n,
  input wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] level,
  output wire [WIDTH-1:0] prev
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;

  // first stage is read only by the second
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign prev = stage3;
endmodule

// ---- verilog/bst_tap.v ----
// boundary scan test access port with controller, instruction and data registers
// Overview of operation
// - power-up enters test-logic-reset, identification instruction current, system runs normally
// - every state change except on reset or test reset follows mode select sampled at test clock rising edge
// - select-dr: low to capture-dr, high to select-ir; registers hold
// - capture-dr parallel-loads selected register if allowed; low shift-dr, high exit1-dr
// - shift-dr moves selected register one stage toward output per rising edge
// - exit1-dr: high to update-dr, low to pause-dr
// - pause-dr halts shifting; stays while low, high to exit2-dr
// - exit2-dr: high to update-dr, low back to shift-dr
// - update-dr falling edge copies shift path to output latches; low idle, high select-dr
// - select-ir: low to capture-ir, high to test-logic-reset; instruction unchanged
// - capture-ir loads fixed value into instruction shift stage; high exit1-ir, low shift-ir
// - shift-ir shifts instruction stage per rising edge; high moves to exit1-ir
// - exit1-ir: low to pause-ir, high to update-ir
// - pause-ir holds while low, high exit2-ir; exit2-ir high update, low shift
// - falling edge in update-ir latches instruction; low idle, high select-dr
// - code 010 selects boundary register, samples pins, shifts from serial input
// - code 000 drives pins from boundary outputs, boundary in path, captures inputs
// - code 111 routes serial input to output through one bypass bit
// - code 001 selects identification register, loaded in capture-dr, shifted out
// - code 100 floats all digital outputs and uses the bypass bit
// - code 011 drives outputs from boundary latches, holds them, uses bypass bit
// - identification register has 32-bit shift stage and 32-bit latched output
`timescale 1ns/1ns
`include "bst_map.vh"
module bst_tap (
  input wire mclk,
  input wire rst_n,
  input wire test_clock,
  input wire test_reset_n,
  input wire test_mode_select,
  input wire test_data_in,
  output reg test_data_out,
  output reg test_data_out_oe,
  input wire [`BST_IN_N-1:0] pin_in,
  input wire [`BST_OUT_N-1:0] core_out,
  input wire core_oe,
  output reg [`BST_OUT_N-1:0] pin_out,
  output reg [`BST_OUT_N-1:0] pin_out_oe,
  output wire [`BST_IR_LEN-1:0] instr,
  output wire [`BST_ID_LEN-1:0] id_latched
);

  // decides the next controller state from mode select
  function [3:0] tap_next;
    input [3:0] st;
    input tms;
    begin
      case (st)
        `BST_ST_RESET: tap_next = tms ? `BST_ST_RESET : `BST_ST_IDLE;
        `BST_ST_IDLE: tap_next = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
        `BST_ST_SEL_DR: tap_next = tms ? `BST_ST_SEL_IR : `BST_ST_CAP_DR;
        `BST_ST_CAP_DR: tap_next = tms ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
        `BST_ST_SHIFT_DR: tap_next = tms ? `BST_ST_EXIT1_DR : `BST_ST_SHIFT_DR;
        `BST_ST_EXIT1_DR: tap_next = tms ? `BST_ST_UPD_DR : `BST_ST_PAUSE_DR;
        `BST_ST_PAUSE_DR: tap_next = tms ? `BST_ST_EXIT2_DR : `BST_ST_PAUSE_DR;
        `BST_ST_EXIT2_DR: tap_next = tms ? `BST_ST_UPD_DR : `BST_ST_SHIFT_DR;
        `BST_ST_UPD_DR: tap_next = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
        `BST_ST_SEL_IR: tap_next = tms ? `BST_ST_RESET : `BST_ST_CAP_IR;
        `BST_ST_CAP_IR: tap_next = tms ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
        `BST_ST_SHIFT_IR: tap_next = tms ? `BST_ST_EXIT1_IR : `BST_ST_SHIFT_IR;
        `BST_ST_EXIT1_IR: tap_next = tms ? `BST_ST_UPD_IR : `BST_ST_PAUSE_IR;
        `BST_ST_PAUSE_IR: tap_next = tms ? `BST_ST_EXIT2_IR : `BST_ST_PAUSE_IR;
        `BST_ST_EXIT2_IR: tap_next = tms ? `BST_ST_UPD_IR : `BST_ST_SHIFT_IR;
        `BST_ST_UPD_IR: tap_next = tms ? `BST_ST_SEL_DR : `BST_ST_IDLE;
        default: tap_next = `BST_ST_RESET;
      endcase
    end
  endfunction

  // true when the instruction puts the boundary register in the path
  function sel_bsr;
    input [`BST_IR_LEN-1:0] op;
    begin
      sel_bsr = (op == `BST_OP_SAMPLE) || (op == `BST_OP_EXTEST);
    end
  endfunction

  // true when the instruction puts the identification register in the path
  function sel_id;
    input [`BST_IR_LEN-1:0] op;
    begin
      sel_id = (op == `BST_OP_IDCODE);
    end
  endfunction

  // true when boundary latches drive the output pins
  function drive_bsr;
    input [`BST_IR_LEN-1:0] op;
    begin
      drive_bsr = (op == `BST_OP_EXTEST) || (op == `BST_OP_CLAMP);
    end
  endfunction

  wire [`BST_SY_N-1:0] sy_level;
  wire [`BST_SY_N-1:0] sy_prev;
  wire tck_rise;
  wire tck_fall;
  wire tms;
  wire tdi;
  wire trst;
  wire [`BST_IN_N-1:0] pin_sampled;
  wire [`BST_ID_LEN-1:0] id_value;

  reg [3:0] state;
  reg [`BST_IR_LEN-1:0] ir_shift;
  reg [`BST_IR_LEN-1:0] ir_cur;
  reg bypass;
  reg [`BST_ID_LEN-1:0] id_shift;
  reg [`BST_ID_LEN-1:0] id_hold;
  reg [`BST_BS_LEN-1:0] bs_shift;
  reg [`BST_BS_LEN-1:0] bs_hold;
  reg next_tdo;
  reg [`BST_OUT_N-1:0] next_pin_out;
  reg [`BST_OUT_N-1:0] next_pin_oe;

  // all pins from the tester and the board cross two flops first
  bst_sync #(
    .WIDTH(`BST_SY_N)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in({pin_in, test_reset_n, test_data_in, test_mode_select, test_clock}),
    .level(sy_level),
    .prev(sy_prev)
  );

  // test clock edges as one-cycle strobes on mclk
  assign tck_rise = sy_level[`BST_SY_TCK] & ~sy_prev[`BST_SY_TCK];
  assign tck_fall = ~sy_level[`BST_SY_TCK] & sy_prev[`BST_SY_TCK];
  assign tms = sy_level[`BST_SY_TMS];
  assign tdi = sy_level[`BST_SY_TDI];
  assign trst = ~sy_level[`BST_SY_TRST];
  assign pin_sampled = sy_level[`BST_SY_PIN_HI:`BST_SY_PIN_LO];
  assign id_value = {`BST_ID_REV, `BST_ID_PART, `BST_ID_MAKER, `BST_ID_MARK};

  assign instr = ir_cur;
  assign id_latched = id_hold;

  // controller steps only on a test clock rising edge
  always @(posedge mclk)
  begin
    if (!rst_n || trst)
      state <= `BST_ST_RESET;
    else if (tck_rise)
      state <= tap_next(state, tms);
  end

  // instruction shift stage: capture fixed value, shift lsb first
  always @(posedge mclk)
  begin
    if (!rst_n || trst)
      ir_shift <= `BST_IR_CAPTURE;
    else if (tck_rise)
    begin
      if (state == `BST_ST_CAP_IR)
        ir_shift <= `BST_IR_CAPTURE;
      else if (state == `BST_ST_SHIFT_IR)
        ir_shift <= {tdi, ir_shift[`BST_IR_LEN-1:1]};
    end
  end

  // current instruction: forced in reset, latched on falling edge in update-ir
  always @(posedge mclk)
  begin
    if (!rst_n || trst)
      ir_cur <= `BST_OP_IDCODE;
    else if (state == `BST_ST_RESET)
      ir_cur <= `BST_OP_IDCODE;
    else if (tck_fall && state == `BST_ST_UPD_IR)
      ir_cur <= ir_shift;
  end

  // bypass bit: captures zero, shifts the serial input
  always @(posedge mclk)
  begin
    if (!rst_n)
      bypass <= 1'b0;
    else if (tck_rise && !sel_bsr(ir_cur) && !sel_id(ir_cur))
    begin
      if (state == `BST_ST_CAP_DR)
        bypass <= 1'b0;
      else if (state == `BST_ST_SHIFT_DR)
        bypass <= tdi;
    end
  end

  // identification shift stage and its latched copy
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      id_shift <= {`BST_ID_LEN{1'b0}};
      id_hold <= {`BST_ID_LEN{1'b0}};
    end
    else if (sel_id(ir_cur))
    begin
      if (tck_rise && state == `BST_ST_CAP_DR)
        id_shift <= id_value;
      else if (tck_rise && state == `BST_ST_SHIFT_DR)
        id_shift <= {tdi, id_shift[`BST_ID_LEN-1:1]};
      else if (tck_fall && state == `BST_ST_UPD_DR)
        id_hold <= id_shift;
    end
  end

  // boundary chain: capture pins and core, shift, latch on update falling edge
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      bs_shift <= {`BST_BS_LEN{1'b0}};
      bs_hold <= {`BST_BS_LEN{1'b0}};
    end
    else if (sel_bsr(ir_cur))
    begin
      if (tck_rise && state == `BST_ST_CAP_DR)
        bs_shift <= {core_oe, core_out, pin_sampled};
      else if (tck_rise && state == `BST_ST_SHIFT_DR)
        bs_shift <= {tdi, bs_shift[`BST_BS_LEN-1:1]};
      else if (tck_fall && state == `BST_ST_UPD_DR)
        bs_hold <= bs_shift;
    end
  end

  // serial output bit of the register in the path
  always @*
  begin
    next_tdo = bypass;
    if (state == `BST_ST_SHIFT_IR)
      next_tdo = ir_shift[0];
    else if (sel_bsr(ir_cur))
      next_tdo = bs_shift[0];
    else if (sel_id(ir_cur))
      next_tdo = id_shift[0];
  end

  // serial output changes on the falling edge and drives only while shifting
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      test_data_out <= 1'b0;
      test_data_out_oe <= 1'b0;
    end
    else if (tck_fall)
    begin
      test_data_out <= next_tdo;
      test_data_out_oe <= (state == `BST_ST_SHIFT_DR) || (state == `BST_ST_SHIFT_IR);
    end
  end

  // output pin source per instruction
  always @*
  begin
    next_pin_out = core_out;
    next_pin_oe = {`BST_OUT_N{core_oe}};
    if (ir_cur == `BST_OP_HIGHZ)
    begin
      next_pin_out = core_out;
      next_pin_oe = {`BST_OUT_N{1'b0}};
    end
    else if (drive_bsr(ir_cur))
    begin
      next_pin_out = bs_hold[`BST_BS_OUT_HI:`BST_BS_OUT_LO];
      next_pin_oe = {`BST_OUT_N{bs_hold[`BST_BS_CTL]}};
    end
  end

  // registered pins; normal operation unless a driving test instruction or code 100 is current
  always @(posedge mclk)
  begin
    if (!rst_n)
    begin
      pin_out <= {`BST_OUT_N{1'b0}};
      pin_out_oe <= {`BST_OUT_N{1'b0}};
    end
    else
    begin
      pin_out <= next_pin_out;
      pin_out_oe <= next_pin_oe;
    end
  end

endmodule
